// ===== rtl/iopc_pkg.sv
// Package: register map, field layout and encodings of the I/O port controller
package iopc_pkg;
   localparam int NPINS = 8;
   localparam int NOE   = 16;
   localparam int AW    = 8;
   localparam int DW    = 8;

   // Port-wide register view
   localparam logic [7:0] A_DM0   = 8'h00;
   localparam logic [7:0] A_DM1   = 8'h01;
   localparam logic [7:0] A_DM2   = 8'h02;
   localparam logic [7:0] A_OUT   = 8'h03;
   localparam logic [7:0] A_LVL   = 8'h04;
   localparam logic [7:0] A_SLW   = 8'h05;
   localparam logic [7:0] A_IBD   = 8'h06;
   localparam logic [7:0] A_BIE   = 8'h07;
   localparam logic [7:0] A_IT0   = 8'h08;
   localparam logic [7:0] A_IT1   = 8'h09;
   localparam logic [7:0] A_IST   = 8'h0A;
   localparam logic [7:0] A_CTL   = 8'h0B;
   localparam logic [7:0] A_REG   = 8'h0C;
   localparam logic [7:0] A_THR   = 8'h0D;
   // Per-pin register view: base + pin index
   localparam logic [7:0] A_PIN   = 8'h10;
   localparam logic [7:0] A_OESEL = 8'h20;

   // Pin-view field positions
   localparam int PF_OUT = 0;
   localparam int PF_LVL = 1;
   localparam int PF_DM0 = 2;
   localparam int PF_SLW = 5;
   localparam int PF_BIE = 6;
   localparam int PF_IBD = 7;

   localparam logic [7:0] ZERO8 = 8'h00;

   typedef enum logic [2:0] {
      DM_ANALOG_HIZ  = 3'b000,
      DM_DIGITAL_HIZ = 3'b001,
      DM_PULL_UP     = 3'b010,
      DM_PULL_DOWN   = 3'b011,
      DM_OD_LOW      = 3'b100,
      DM_OD_HIGH     = 3'b101,
      DM_STRONG      = 3'b110,
      DM_PULL_BOTH   = 3'b111
   } iopc_dm_t;

   typedef enum logic [1:0] {
      IT_OFF  = 2'b00,
      IT_RISE = 2'b01,
      IT_FALL = 2'b10,
      IT_BOTH = 2'b11
   } iopc_it_t;

   typedef enum logic [1:0] {
      TH_HALF_IO  = 2'b00,
      TH_0P4_IO   = 2'b01,
      TH_HALF_REF = 2'b10,
      TH_REF      = 2'b11
   } iopc_thr_t;
endpackage

// ===== rtl/iopc_drive.sv
// Per-pin output stage decoder: drive mode and data to driver enables
`timescale 1ns/1ps
`default_nettype none
module iopc_drive
   import iopc_pkg::*;
(
   input  wire logic [2:0] mode_in,
   input  wire logic       data_in,
   input  wire logic       regulated_in,
   output logic            strong_hi_out,
   output logic            strong_lo_out,
   output logic            res_hi_out,
   output logic            res_lo_out
);
   iopc_dm_t m;
   assign m = iopc_dm_t'(mode_in);

   always_comb
   begin
      strong_hi_out = 1'b0;
      strong_lo_out = 1'b0;
      res_hi_out    = 1'b0;
      res_lo_out    = 1'b0;
      unique case (m)
         DM_ANALOG_HIZ, DM_DIGITAL_HIZ:
         begin
         end
         // Regulated special pins fall back to open drain here  [RQ5]
         DM_PULL_UP:
         begin
            res_hi_out    = data_in & ~regulated_in;        // [RQ4]
            strong_lo_out = ~data_in;
         end
         DM_PULL_DOWN:
         begin
            strong_hi_out = data_in;                        // [RQ4]
            res_lo_out    = ~data_in & ~regulated_in;
         end
         DM_OD_LOW:  strong_lo_out = ~data_in;              // [RQ6]
         DM_OD_HIGH: strong_hi_out = data_in;               // [RQ6]
         DM_STRONG:
         begin
            strong_hi_out = data_in;                        // [RQ7]
            strong_lo_out = ~data_in;
         end
         DM_PULL_BOTH:
         begin
            res_hi_out = data_in & ~regulated_in;           // [RQ8] [RQ5]
            res_lo_out = ~data_in & ~regulated_in;
         end
      endcase
   end
endmodule // iopc_drive
`default_nettype wire

// ===== rtl/iopc_port.sv
// Eight-pin I/O port controller with drive modes, edge interrupts and special-pin control
//
// Functional notes
// RQ1: After reset all pins analog high-Z, driver off, input buffer off.
// RQ2: Analog high-Z pins present no digital input value; edge detection still samples such pins and can set status and request.
// RQ3: Digital high-Z: driver off, input buffer on.
// RQ4: Pull-up/down modes: resistor for one data value, strong drive for other.
// RQ5: Regulated special pins offer no resistive pull modes.
// RQ6: Open-drain modes float for one value, drive strongly for the other.
// RQ7: Strong mode drives both levels; software avoids using it as input.
// RQ8: Combined resistive mode: pull-up when data high, pull-down when low.
// RQ9: Per-pin register gathers eight configuration bits of one pin.
// RQ10: Port-wide view, bit per pin, shares state with pin view.
// RQ11: Bidirectional: routed enable low gives digital high-Z, high gives drive mode.
// RQ12: Up to 16 output-enable signals, each routable to any pins.
// RQ13: Per-pin slew option, active only in strong and open-drain modes.
// RQ14: Software picks slow edges below 1 MHz, fast up to 33 MHz.
// RQ15: All eight pins feed one port interrupt request line.
// RQ16: Per-pin edge select: off, rising, falling or both.
// RQ17: Configured edge sets pin status bit and raises port request.
// RQ18: Only edge detection; no level-sensitive interrupts.
// RQ19: Port-wide CMOS/LVTTL threshold; per-pin input buffer disable.
// RQ20: Each special pin selects supply or regulated high output level.
// RQ21: Special pins paired per reference; four high-threshold choices.
// RQ22: Software uses high-Z, open-drain low or pull-down for overvoltage tolerance.
// RQ23: Drive mode is a three-bit code, 000 through 111.
// RQ24: Pin level read through a register separate from output latch.
// RQ25: Pins hold configured state through low-power modes until changed or reset.
// RQ26: Edge inputs synchronised; edge found by comparing with previous sample.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module iopc_port
   import iopc_pkg::*;
#(
   parameter int N_PINS = NPINS,
   parameter int N_OE   = NOE
)
(
   input  wire logic              mclk_in,
   input  wire logic              rst_in,
   input  wire logic [AW-1:0]     addr_in,
   input  wire logic [DW-1:0]     wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [DW-1:0]     rdata_out,
   input  wire logic [N_PINS-1:0] pin_in,
   input  wire logic [N_OE-1:0]   aux_oe_in,
   output logic      [N_PINS-1:0] strong_hi_out,
   output logic      [N_PINS-1:0] strong_lo_out,
   output logic      [N_PINS-1:0] res_hi_out,
   output logic      [N_PINS-1:0] res_lo_out,
   output logic      [N_PINS-1:0] slow_edge_out,
   output logic      [N_PINS-1:0] in_buf_en_out,
   output logic                   lvttl_out,
   output logic      [N_PINS-1:0] regulated_out,
   output logic      [N_PINS-1:0] sys_in_out,
   output logic                   irq_out,
   output logic      [7:0]        thr_sel_out
);
   localparam int OSW = $clog2(N_OE);

   // Configuration state; held through low-power modes since only writes and reset change it [RQ25]
   logic [N_PINS-1:0] dm0_q, dm1_q, dm2_q, out_q, slw_q, ibd_q, bie_q, it0_q, it1_q;
   logic [N_PINS-1:0] dm0_d, dm1_d, dm2_d, out_d, slw_d, ibd_d, bie_d, it0_d, it1_d;
   logic [N_PINS-1:0] ist_q, ist_d, reg_q, reg_d;
   logic              lvttl_q, lvttl_d;
   logic [7:0]        thr_q, thr_d;
   logic [OSW-1:0]    oesel_q [N_PINS];
   logic [N_PINS-1:0] sync1_q, sync2_q, prev_q;
   logic [DW-1:0]     rdata_q, rdata_d;

   // Address decode
   wire pin_hit = wr_in && (addr_in[7:4] == A_PIN[7:4]) && (addr_in[3:0] < N_PINS);
   wire sel_hit = wr_in && (addr_in[7:4] == A_OESEL[7:4]) && (addr_in[3:0] < N_PINS);
   wire [3:0] widx = addr_in[3:0];
   wire wr_dm0 = wr_in && (addr_in == A_DM0);
   wire wr_dm1 = wr_in && (addr_in == A_DM1);
   wire wr_dm2 = wr_in && (addr_in == A_DM2);
   wire wr_out = wr_in && (addr_in == A_OUT);
   wire wr_slw = wr_in && (addr_in == A_SLW);
   wire wr_ibd = wr_in && (addr_in == A_IBD);
   wire wr_bie = wr_in && (addr_in == A_BIE);
   wire wr_it0 = wr_in && (addr_in == A_IT0);
   wire wr_it1 = wr_in && (addr_in == A_IT1);
   wire wr_ist = wr_in && (addr_in == A_IST);
   wire wr_ctl = wr_in && (addr_in == A_CTL);
   wire wr_reg = wr_in && (addr_in == A_REG);
   wire wr_thr = wr_in && (addr_in == A_THR);

   logic [N_PINS-1:0] edge_ev;
   logic [N_PINS-1:0] in_en;
   logic [N_PINS-1:0] shi, slo, rhi, rlo, slow_c;
   logic [DW-1:0]     pin_word [N_PINS];

   genvar g;
   generate
      for (g = 0; g < N_PINS; g++)
      begin : g_pin
         wire [2:0] mode_cfg = {dm2_q[g], dm1_q[g], dm0_q[g]};             // [RQ23]
         wire       oe_route = aux_oe_in[oesel_q[g]];                      // [RQ12]
         wire       bidir_in = bie_q[g] && !oe_route;
         wire [2:0] mode_eff = bidir_in ? DM_DIGITAL_HIZ : mode_cfg;       // [RQ11]
         wire       is_strong_od = (mode_eff[2] == 1'b1) && (mode_eff != DM_PULL_BOTH);
         wire       sel_this = pin_hit && (widx == 4'(g));
         wire       sel_oe   = sel_hit && (widx == 4'(g));

         iopc_drive u_drive (
            .mode_in       (mode_eff),
            .data_in       (out_q[g]),
            .regulated_in  (reg_q[g]),
            .strong_hi_out (shi[g]),
            .strong_lo_out (slo[g]),
            .res_hi_out    (rhi[g]),
            .res_lo_out    (rlo[g])
         );

         assign slow_c[g] = slw_q[g] && is_strong_od;                    // [RQ13]
         // Analog high-Z and per-pin disable kill the input buffer [RQ2] [RQ3] [RQ19]
         assign in_en[g] = (mode_eff != DM_ANALOG_HIZ) && !ibd_q[g];

         // Edge from synchronised sample versus previous one [RQ26] [RQ16] [RQ18]
         assign edge_ev[g] = (it0_q[g] && sync2_q[g] && !prev_q[g])
                          || (it1_q[g] && !sync2_q[g] && prev_q[g]);

         assign pin_word[g] = {ibd_q[g], bie_q[g], slw_q[g], dm2_q[g], dm1_q[g], dm0_q[g],
                               sync2_q[g] & in_en[g], out_q[g]};          // [RQ9]

         // Both register views write the same bits [RQ10]
         assign dm0_d[g] = sel_this ? wdata_in[PF_DM0]   : wr_dm0 ? wdata_in[g] : dm0_q[g];
         assign dm1_d[g] = sel_this ? wdata_in[PF_DM0+1] : wr_dm1 ? wdata_in[g] : dm1_q[g];
         assign dm2_d[g] = sel_this ? wdata_in[PF_DM0+2] : wr_dm2 ? wdata_in[g] : dm2_q[g];
         assign out_d[g] = sel_this ? wdata_in[PF_OUT]   : wr_out ? wdata_in[g] : out_q[g];
         assign slw_d[g] = sel_this ? wdata_in[PF_SLW]   : wr_slw ? wdata_in[g] : slw_q[g];
         assign bie_d[g] = sel_this ? wdata_in[PF_BIE]   : wr_bie ? wdata_in[g] : bie_q[g];
         assign ibd_d[g] = sel_this ? wdata_in[PF_IBD]   : wr_ibd ? wdata_in[g] : ibd_q[g];
         assign it0_d[g] = wr_it0 ? wdata_in[g] : it0_q[g];
         assign it1_d[g] = wr_it1 ? wdata_in[g] : it1_q[g];
         assign reg_d[g] = wr_reg ? wdata_in[g] : reg_q[g];                // [RQ20]
         // Write one to clear; a new edge wins over the clear [RQ17]
         assign ist_d[g] = edge_ev[g] || (ist_q[g] && !(wr_ist && wdata_in[g]));

         always_ff @(posedge mclk_in)
         begin
            if (rst_in)
               oesel_q[g] <= '0;
            else if (sel_oe)
               oesel_q[g] <= wdata_in[OSW-1:0];
         end
      end
   endgenerate

   assign lvttl_d = wr_ctl ? wdata_in[0] : lvttl_q;                       // [RQ19]
   assign thr_d   = wr_thr ? wdata_in : thr_q;                            // [RQ21]

   // Read mux; level view separate from output latch [RQ24]
   always_comb
   begin
      rdata_d = ZERO8;
      if (rd_in)
      begin
         if (addr_in[7:4] == A_PIN[7:4] && addr_in[3:0] < N_PINS)
            rdata_d = pin_word[addr_in[2:0]];
         else if (addr_in[7:4] == A_OESEL[7:4] && addr_in[3:0] < N_PINS)
            rdata_d = DW'(oesel_q[addr_in[2:0]]);
         else
         begin
            unique case (addr_in)
               A_DM0:   rdata_d = dm0_q;
               A_DM1:   rdata_d = dm1_q;
               A_DM2:   rdata_d = dm2_q;
               A_OUT:   rdata_d = out_q;
               A_LVL:   rdata_d = sync2_q & in_en;                     // [RQ2]
               A_SLW:   rdata_d = slw_q;
               A_IBD:   rdata_d = ibd_q;
               A_BIE:   rdata_d = bie_q;
               A_IT0:   rdata_d = it0_q;
               A_IT1:   rdata_d = it1_q;
               A_IST:   rdata_d = ist_q;
               A_CTL:   rdata_d = {7'h00, lvttl_q};
               A_REG:   rdata_d = reg_q;
               A_THR:   rdata_d = thr_q;
               default: rdata_d = ZERO8;
            endcase
         end
      end
   end

   // Drive configuration, all cleared to analog high-Z [RQ1]
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         {dm0_q, dm1_q, dm2_q, out_q} <= '0;
      else
         {dm0_q, dm1_q, dm2_q, out_q} <= {dm0_d, dm1_d, dm2_d, out_d};
   end

   // Slew, input-buffer disable and bidirectional enable
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         {slw_q, ibd_q, bie_q} <= '0;
      else
         {slw_q, ibd_q, bie_q} <= {slw_d, ibd_d, bie_d};
   end

   // Edge selects
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         {it0_q, it1_q} <= '0;
      else
         {it0_q, it1_q} <= {it0_d, it1_d};
   end

   // Special-pin levels and port threshold type
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         {reg_q, lvttl_q, thr_q} <= '0;
      else
         {reg_q, lvttl_q, thr_q} <= {reg_d, lvttl_d, thr_d};
   end

   // Two-stage synchroniser and previous sample
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;                  // [RQ26]
         prev_q  <= sync2_q;
      end
   end

   // Per-pin edge status
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         ist_q <= '0;
      else
         ist_q <= ist_d;
   end

   // Registered outputs, one short process each
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         strong_hi_out <= '0;
      else
         strong_hi_out <= shi;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         strong_lo_out <= '0;
      else
         strong_lo_out <= slo;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         res_hi_out <= '0;
      else
         res_hi_out <= rhi;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         res_lo_out <= '0;
      else
         res_lo_out <= rlo;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         slow_edge_out <= '0;
      else
         slow_edge_out <= slow_c;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         in_buf_en_out <= '0;
      else
         in_buf_en_out <= in_en;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         lvttl_out <= 1'b0;
      else
         lvttl_out <= lvttl_q;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         regulated_out <= '0;
      else
         regulated_out <= reg_q;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         sys_in_out <= '0;
      else
         sys_in_out <= sync2_q & in_en;       // [RQ2]
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         irq_out <= 1'b0;
      else
         irq_out <= |ist_d;                   // [RQ15] [RQ17]
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         thr_sel_out <= '0;
      else
         thr_sel_out <= thr_q;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         rdata_out <= '0;
      else
         rdata_out <= rdata_d;
   end
endmodule // iopc_port
`default_nettype wire

// ===== verification/iopc_pin_model.sv
// Board-side model of the circuits on the eight port pins
`timescale 1ns/1ps
`default_nettype none
module iopc_pin_model
#(
   parameter logic FLOAT_LVL = 1'b1
)
(
   input  wire logic [7:0] strong_hi_in,
   input  wire logic [7:0] strong_lo_in,
   input  wire logic [7:0] res_hi_in,
   input  wire logic [7:0] res_lo_in,
   input  wire logic [7:0] ext_en_in,
   input  wire logic [7:0] ext_val_in,
   output logic      [7:0] pin_out
);
   // Strong legs beat outside drivers, which beat resistors; idle lines sit on a pull-up
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (strong_hi_in[i] | strong_lo_in[i])
            pin_out[i] = strong_hi_in[i];
         else if (ext_en_in[i])
            pin_out[i] = ext_val_in[i];
         else if (res_hi_in[i] | res_lo_in[i])
            pin_out[i] = res_hi_in[i];
         else
            pin_out[i] = FLOAT_LVL;
      end
   end
endmodule // iopc_pin_model
`default_nettype wire

// ===== verification/iopc_port_checker.sv
// Port-level assertions for the I/O port controller
`timescale 1ns/1ps
`default_nettype none
module iopc_port_checker
   import iopc_pkg::*;
#(
   parameter int N_PINS = NPINS,
   parameter int N_OE   = NOE
)
(
   input  wire logic              mclk_in,
   input  wire logic              rst_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   input  wire logic [AW-1:0]     addr_in,
   input  wire logic [DW-1:0]     wdata_in,
   input  wire logic [DW-1:0]     rdata_out,
   input  wire logic [N_PINS-1:0] pin_in,
   input  wire logic [N_OE-1:0]   aux_oe_in,
   input  wire logic [N_PINS-1:0] strong_hi_out,
   input  wire logic [N_PINS-1:0] strong_lo_out,
   input  wire logic [N_PINS-1:0] res_hi_out,
   input  wire logic [N_PINS-1:0] res_lo_out,
   input  wire logic [N_PINS-1:0] slow_edge_out,
   input  wire logic [N_PINS-1:0] in_buf_en_out,
   input  wire logic              lvttl_out,
   input  wire logic [N_PINS-1:0] regulated_out,
   input  wire logic [N_PINS-1:0] sys_in_out,
   input  wire logic              irq_out,
   input  wire logic [7:0]        thr_sel_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   a_reset_quiet: assert property ($fell(rst_in) |-> !irq_out &&
      (strong_hi_out | strong_lo_out | res_hi_out | res_lo_out | in_buf_en_out) == '0)
      else $error("outputs active right after reset");
   a_no_digital_in: assert property ((sys_in_out & ~in_buf_en_out) == '0)
      else $error("input value seen with buffer off");
   a_no_crowbar: assert property ((strong_hi_out & strong_lo_out) == '0)
      else $error("both strong legs on");
   a_one_resistor: assert property ((res_hi_out & res_lo_out) == '0)
      else $error("both resistor legs on");
   a_leg_exclusive: assert property (
      ((strong_hi_out | strong_lo_out) & (res_hi_out | res_lo_out)) == '0)
      else $error("strong and resistive leg together");
   a_slew_no_res: assert property ((slow_edge_out & (res_hi_out | res_lo_out)) == '0)
      else $error("slow edge in resistive drive");
   a_regulated_no_res: assert property ((regulated_out & (res_hi_out | res_lo_out)) == '0)
      else $error("resistor on regulated pin");
   a_irq_from_edge: assert property ($rose(irq_out) |->
      $past(pin_in, 2) != $past(pin_in, 3) || $past(pin_in, 3) != $past(pin_in, 4) ||
      $past(pin_in, 4) != $past(pin_in, 5))
      else $error("request without a pin edge");
   a_irq_clear: assert property ($fell(irq_out) |->
      $past(wr_in) && $past(addr_in) == A_IST)
      else $error("request dropped without status clear");
endmodule // iopc_port_checker
bind iopc_port iopc_port_checker #(.N_PINS(N_PINS), .N_OE(N_OE)) u_chk (
   .mclk_in(mclk_in), .rst_in(rst_in), .wr_in(wr_in), .rd_in(rd_in), .lvttl_out(lvttl_out),
   .irq_out(irq_out), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
   .aux_oe_in(aux_oe_in), .thr_sel_out(thr_sel_out), .pin_in(pin_in),
   .strong_hi_out(strong_hi_out), .strong_lo_out(strong_lo_out), .res_hi_out(res_hi_out),
   .res_lo_out(res_lo_out), .slow_edge_out(slow_edge_out), .in_buf_en_out(in_buf_en_out),
   .regulated_out(regulated_out), .sys_in_out(sys_in_out));
`default_nettype wire

// ===== verification/iopc_port_tb.sv
// Self-checking bench for the I/O port controller
`timescale 1ns/1ps
`default_nettype none
module iopc_port_tb;
   import iopc_pkg::*;
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
   // Drive legs {strong_hi, strong_lo, res_hi, res_lo} per {mode, data}
   localparam logic [63:0] EXPV = 64'h2184_8004_8124_0000;
   logic        mclk_in, rst_in, wr_in, rd_in, lvttl_out, irq_out;
   logic [7:0]  addr_in, wdata_in, rdata_out, pin_in, ext_en, ext_val, rd_q;
   logic [7:0]  strong_hi_out, strong_lo_out, res_hi_out, res_lo_out, slow_edge_out;
   logic [7:0]  in_buf_en_out, regulated_out, sys_in_out, thr_sel_out;
   logic [15:0] aux_oe_in;
   int          err_count, cmp_count, cyc;
   wire  [3:0]  pin2_legs = {strong_hi_out[2], strong_lo_out[2], res_hi_out[2], res_lo_out[2]};
   wire  [7:0]  all_legs  = strong_hi_out | strong_lo_out | res_hi_out | res_lo_out;
   iopc_port dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in),
      .aux_oe_in(aux_oe_in), .strong_hi_out(strong_hi_out), .strong_lo_out(strong_lo_out),
      .res_hi_out(res_hi_out), .res_lo_out(res_lo_out), .slow_edge_out(slow_edge_out),
      .in_buf_en_out(in_buf_en_out), .lvttl_out(lvttl_out), .regulated_out(regulated_out),
      .sys_in_out(sys_in_out), .irq_out(irq_out), .thr_sel_out(thr_sel_out));
   iopc_pin_model u_pins (.strong_hi_in(strong_hi_out), .strong_lo_in(strong_lo_out),
      .res_hi_in(res_hi_out), .res_lo_in(res_lo_out), .ext_en_in(ext_en),
      .ext_val_in(ext_val), .pin_out(pin_in));
   initial
   begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         wrap_up();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   task automatic pins(input logic [7:0] v);
      @(posedge mclk_in);
      ext_val <= v;
      wt(6);
   endtask
   task automatic t_modes();
      logic [2:0] m;
      for (int i = 0; i < 16; i++)
      begin
         m = i[3:1];
         wr(A_PIN + 8'h02, {2'b00, 1'b1, m, 1'b0, i[0]});
         wt(5);
         `CHK("drive", EXPV[4*i +: 4], pin2_legs)
         `CHK("inbuf", m != 3'b000, in_buf_en_out[2])
         `CHK("gate", (m != 3'b000) & pin_in[2], sys_in_out[2])
         `CHK("slew", m inside {3'b100, 3'b101, 3'b110}, slow_edge_out[2])
      end
   endtask
   task automatic t_ports();
      wr(A_SLW, ZERO8);
      wr(A_DM0, ZERO8);
      wr(A_DM1, 8'hFF);
      wr(A_DM2, 8'hFF);
      wr(A_OUT, 8'hAA);
      wt(5);
      `CHK("strong hi", 8'hAA, strong_hi_out)
      `CHK("strong lo", 8'h55, strong_lo_out)
      rd(A_PIN + 8'h01, rd_q);
      `CHK("pin view", 8'h1B, rd_q)
      rd(A_LVL, rd_q);
      `CHK("level", 8'hAA, rd_q)
      wr(A_PIN + 8'h07, 8'h04);
      rd(A_DM0, rd_q);
      `CHK("dm0", 8'h80, rd_q)
      rd(8'h3F, rd_q);
      `CHK("unmapped", ZERO8, rd_q)
   endtask
   task automatic t_bidir();
      wr(A_OESEL + 8'h04, 8'h05);
      wr(A_PIN + 8'h04, 8'h59);
      aux_oe_in <= 16'hFFDF;
      wt(4);
      `CHK("oe off", 2'b01, {strong_hi_out[4], in_buf_en_out[4]})
      @(posedge mclk_in);
      aux_oe_in <= 16'h0020;
      wt(4);
      `CHK("oe on", 1'b1, strong_hi_out[4])
   endtask
   task automatic t_irq();
      wr(A_PIN + 8'h04, 8'h04);
      wr(A_DM0, 8'hFF);
      wr(A_DM1, ZERO8);
      wr(A_DM2, ZERO8);
      ext_en <= 8'hFF;
      pins(ZERO8);
      wr(A_IST, 8'hFF);
      wr(A_IT0, 8'h05);
      wr(A_IT1, 8'h06);
      wt(3);
      `CHK("irq idle", 1'b0, irq_out)
      pins(8'h0F);
      `CHK("sys in", 8'h0F, sys_in_out)
      `CHK("irq set", 1'b1, irq_out)
      rd(A_IST, rd_q);
      `CHK("rise status", 8'h05, rd_q)
      wr(A_IST, 8'h05);
      wt(2);
      `CHK("irq clear", 1'b0, irq_out)
      pins(ZERO8);
      rd(A_IST, rd_q);
      `CHK("fall status", 8'h06, rd_q)
      wr(A_IST, 8'h06);
      wt(6);
      `CHK("no level", 1'b0, irq_out)
      wr(A_IBD, 8'hFF);
      wr(A_CTL, 8'h01);
      wt(5);
      `CHK("buf off", ZERO8, in_buf_en_out | sys_in_out)
      `CHK("lvttl", 1'b1, lvttl_out)
   endtask
   task automatic t_special();
      wr(A_REG, 8'h01);
      wr(A_PIN, 8'h09);
      wr(A_THR, 8'hE4);
      wt(3);
      `CHK("regulated", 8'h01, regulated_out)
      `CHK("no pull", 1'b0, res_hi_out[0])
      `CHK("threshold", 8'hE4, thr_sel_out)
   endtask
   initial
   begin
      {rst_in, wr_in, rd_in} = 3'b100;
      {addr_in, wdata_in, ext_en, ext_val} = '0;
      aux_oe_in = '0;
      repeat (16) @(posedge mclk_in);
      rst_in <= 1'b0;
      wt(1);
      `CHK("reset", ZERO8, all_legs | in_buf_en_out)
      t_modes();
      t_ports();
      t_bidir();
      t_irq();
      t_special();
      wrap_up();
   end
endmodule // iopc_port_tb
`default_nettype wire
